// ==== src/bfd_chain.sv ====
// per-channel offset, baseline, filter and sample-skip chain
`timescale 1ns/10ps
`include "bfd_regs.svh"
// What this block does
// - subtract a per-core calibration offset, chosen by the producing core
// - add a signed user offset on top of the calibration
// - baseline stabilizer drives the baseline to a 22-bit target level
// - stabilizer tracks the baseline continuously without stalling samples
// - software can disable the stabilizer; samples then pass uncorrected
// - one baseline estimate per core, correcting each core separately
// - programmable low-pass filter follows the stabilizer
// - skip factor M keeps only every Mth sample
// - skipping works with the filter on or bypassed
// - skipping never changes sample values or their offset
// - record holds a fixed retained count; skipping stretches its time span
// - each channel has its own chain with its own filter settings
module bfd_chain #(
   parameter int unsigned REC_LEN = `BFD_REC_LEN
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire bfd_pkg::bfd_in_t smp_in,
   output bfd_pkg::bfd_out_t smp_out
);
   import bfd_pkg::*;

   localparam int DW = `BFD_DW;
   localparam int IW = `BFD_IW;

   // bus side state
   bfd_cfg_t pend, next_pend;
   logic [`BFD_NCORE-1:0][15:0] cal, next_cal;
   logic ack, next_ack;
   logic [31:0] rdat, next_rdat;

   // chain state
   bfd_cfg_t act, next_act;
   bfd_smp_t s1, next_s1, s2, next_s2, s3, next_s3;
   logic [`BFD_NCORE-1:0][DW-1:0] est, next_est;
   logic [`BFD_NTAP-2:0][DW-1:0] tap, next_tap;
   logic [7:0] scnt, next_scnt;
   logic [15:0] rcnt, next_rcnt;
   logic in_rec, next_in_rec;
   bfd_out_t sout, next_sout;

   logic req;
   logic load;
   bfd_cfg_t cur;

   // byte-lane merge of a write
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   assign req = wb_cyc_i & wb_stb_i & ~ack;
   assign wb_ack_o = ack;
   assign wb_dat_o = rdat;
   assign smp_out = sout;

   // register writes and read mux, one wait state
   always_comb begin
      logic [31:0] m;
      m = 32'h00000000;
      next_pend = pend;
      next_cal = cal;
      next_ack = req;
      next_rdat = 32'h00000000;
      if (req && wb_we_i) begin
         case (wb_adr_i)
            `BFD_OFF_CTRL: begin
               m = wmerge({30'h00000000, pend.filt_en, pend.stab_en}, wb_dat_i, wb_sel_i);
               next_pend.stab_en = m[`BFD_CTRL_STAB];
               next_pend.filt_en = m[`BFD_CTRL_FILT];
            end
            `BFD_OFF_UOFF: begin
               m = wmerge({16'h0000, pend.uoff}, wb_dat_i, wb_sel_i);
               next_pend.uoff = m[15:0];
            end
            `BFD_OFF_TARGET: begin
               m = wmerge({10'h000, pend.target}, wb_dat_i, wb_sel_i);
               next_pend.target = m[21:0];
            end
            `BFD_OFF_SKIP: begin
               m = wmerge({24'h000000, pend.skip}, wb_dat_i, wb_sel_i);
               next_pend.skip = m[7:0];
            end
            default: begin
               for (int i = 0; i < `BFD_NCORE; i++) begin
                  if (wb_adr_i == 8'(`BFD_OFF_CAL + 4 * i)) begin
                     m = wmerge({16'h0000, cal[i]}, wb_dat_i, wb_sel_i);
                     next_cal[i] = m[15:0];
                  end
               end
               for (int i = 0; i < `BFD_NTAP; i++) begin
                  if (wb_adr_i == 8'(`BFD_OFF_COEF + 4 * i)) begin
                     m = wmerge({24'h000000, pend.coef[i]}, wb_dat_i, wb_sel_i);
                     next_pend.coef[i] = m[7:0];
                  end
               end
            end
         endcase
      end
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            `BFD_OFF_CTRL: next_rdat = {30'h00000000, pend.filt_en, pend.stab_en};
            `BFD_OFF_UOFF: next_rdat = {16'h0000, pend.uoff};
            `BFD_OFF_TARGET: next_rdat = {10'h000, pend.target};
            `BFD_OFF_SKIP: next_rdat = {24'h000000, pend.skip};
            `BFD_OFF_STAT: next_rdat = {15'h0000, in_rec, rcnt};
            default: begin
               for (int i = 0; i < `BFD_NCORE; i++) begin
                  if (wb_adr_i == 8'(`BFD_OFF_CAL + 4 * i)) begin
                     next_rdat = {16'h0000, cal[i]};
                  end
                  if (wb_adr_i == 8'(`BFD_OFF_EST + 4 * i)) begin
                     next_rdat = 32'($signed(est[i]));
                  end
               end
               for (int i = 0; i < `BFD_NTAP; i++) begin
                  if (wb_adr_i == 8'(`BFD_OFF_COEF + 4 * i)) begin
                     next_rdat = {24'h000000, pend.coef[i]};
                  end
               end
            end
         endcase
      end
   end

   // bus side registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pend.stab_en <= `BFD_RST_STAB;
         pend.filt_en <= `BFD_RST_FILT;
         pend.uoff <= 16'h0000;
         pend.target <= 22'h000000;
         pend.skip <= `BFD_RST_SKIP;
         pend.coef <= {`BFD_NTAP{`BFD_COEF_UNITY}};
         cal <= '0;
         ack <= 1'b0;
         rdat <= 32'h00000000;
      end else begin
         pend <= next_pend;
         cal <= next_cal;
         ack <= next_ack;
         rdat <= next_rdat;
      end
   end

   // a record's first sample loads the pending settings
   assign load = smp_in.vld & smp_in.first;
   assign cur = load ? pend : act;

   // sample path: offset, stabilizer, filter, skip
   always_comb begin
      logic signed [DW-1:0] e;
      logic signed [DW:0] diff;
      logic signed [DW+10:0] acc;
      logic [7:0] reload;
      logic keep;
      logic last;
      e = '0;
      diff = '0;
      acc = '0;
      reload = 8'h00;
      keep = 1'b0;
      last = 1'b0;
      next_act = cur;
      next_est = est;
      next_tap = tap;
      next_scnt = scnt;
      next_rcnt = rcnt;
      next_in_rec = in_rec;
      // stage 1: calibration and user offset, scaled to 8 fraction bits
      next_s1.vld = smp_in.vld;
      next_s1.first = smp_in.first;
      next_s1.core = smp_in.core;
      next_s1.dat = (DW'(smp_in.smp) - DW'($signed(cal[smp_in.core]))
                     + DW'(cur.uoff)) <<< `BFD_FRAC;
      // stage 2: per-core baseline estimate, never stalls the stream
      e = est[s1.core];
      diff = (DW + 1)'(s1.dat) - (DW + 1)'(e);
      next_s2 = s1;
      if (s1.vld && act.stab_en) begin
         next_est[s1.core] = DW'(e + DW'(diff >>> `BFD_STAB_SHIFT));
         next_s2.dat = s1.dat - e + DW'(act.target);
      end
      // stage 3: low-pass filter over the newest taps
      if (s2.vld) begin
         next_tap = {tap[`BFD_NTAP-3:0], s2.dat};
      end
      acc = (DW + 11)'($signed(act.coef[0]) * s2.dat);
      for (int i = 1; i < `BFD_NTAP; i++) begin
         acc = acc + (DW + 11)'($signed(act.coef[i]) * $signed(tap[i-1]));
      end
      next_s3 = s2;
      if (act.filt_en) begin
         next_s3.dat = DW'(acc >>> `BFD_COEF_SHIFT);
      end
      // stage 4: keep every Mth sample, the record's first always kept
      reload = (act.skip == 8'h00) ? 8'h00 : act.skip - 8'h01;
      if (s3.vld) begin
         keep = s3.first || (scnt == 8'h00);
         next_scnt = keep ? reload : scnt - 8'h01;
      end
      next_sout.vld = 1'b0;
      next_sout.first = 1'b0;
      next_sout.last = 1'b0;
      next_sout.dat = s3.dat;
      if (keep && s3.first) begin
         last = (REC_LEN <= 1);
         next_rcnt = 16'h0001;
         next_in_rec = !last;
         next_sout.vld = 1'b1;
         next_sout.first = 1'b1;
         next_sout.last = last;
      end else if (keep && in_rec) begin
         last = (rcnt + 16'h0001 == 16'(REC_LEN));
         next_rcnt = rcnt + 16'h0001;
         next_in_rec = !last;
         next_sout.vld = 1'b1;
         next_sout.last = last;
      end
   end

   // sample path registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         act.stab_en <= `BFD_RST_STAB;
         act.filt_en <= `BFD_RST_FILT;
         act.uoff <= 16'h0000;
         act.target <= 22'h000000;
         act.skip <= `BFD_RST_SKIP;
         act.coef <= {`BFD_NTAP{`BFD_COEF_UNITY}};
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         est <= '0;
         tap <= '0;
         scnt <= 8'h00;
         rcnt <= 16'h0000;
         in_rec <= 1'b0;
         sout <= '0;
      end else begin
         act <= next_act;
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
         est <= next_est;
         tap <= next_tap;
         scnt <= next_scnt;
         rcnt <= next_rcnt;
         in_rec <= next_in_rec;
         sout <= next_sout;
      end
   end

   // estimate of the core at stage 1, for the checks below
   logic signed [DW-1:0] e_now;
   assign e_now = est[s1.core];

   // checks on the chain
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence first_in_s;
      smp_in.vld && smp_in.first;
   endsequence

   sequence first_out_s;
      ##4 (sout.vld && sout.first);
   endsequence

   ack_single_a: assert property (ack |=> !ack)
      else $error("ack held longer than one cycle");

   offset_sum_a: assert property (smp_in.vld |=>
      s1.dat == DW'((DW'($past(smp_in.smp)) - DW'($signed($past(cal[smp_in.core])))
                     + DW'($past(cur.uoff))) <<< `BFD_FRAC))
      else $error("offset stage result wrong");

   stab_target_a: assert property (s1.vld && act.stab_en |=>
      s2.dat == DW'($past(s1.dat) - $past(e_now) + DW'($past(act.target))))
      else $error("stabilized sample misses target");

   stab_off_a: assert property (s1.vld && !act.stab_en |=>
      s2.dat == $past(s1.dat) && $stable(est))
      else $error("disabled stabilizer changed data");

   est_track_a: assert property (s1.vld && act.stab_en && $signed(s1.dat) > $signed(e_now)
      |=> $signed(est[$past(s1.core)]) >= $signed($past(e_now)))
      else $error("baseline estimate moved the wrong way");

   filt_bypass_a: assert property (s2.vld && !act.filt_en |=>
      s3.dat == $past(s2.dat))
      else $error("bypassed filter changed data");

   skip_value_a: assert property (sout.vld |-> sout.dat == $past(s3.dat))
      else $error("skip stage altered a sample");

   skip_gap_a: assert property (sout.vld && act.skip > 8'h01 && !s3.first |=> !sout.vld)
      else $error("skip stage kept adjacent samples");

   first_kept_a: assert property (first_in_s |-> first_out_s)
      else $error("record start lost in the chain");

   cfg_hold_a: assert property (!load |=> $stable(act))
      else $error("settings changed inside a record");

   rec_len_a: assert property (sout.vld && sout.last |-> rcnt == 16'(REC_LEN)
      || sout.first)
      else $error("record closed at wrong count");

   rec_stop_a: assert property (!in_rec && !(s3.vld && s3.first) |=> !sout.vld)
      else $error("sample retained outside a record");

   first_load_a: assert property (load |=> act == $past(pend))
      else $error("settings not taken at record start");

   tap_hold_a: assert property (!s2.vld |=> $stable(tap))
      else $error("filter history moved without a sample");

   rdat_idle_a: assert property (!ack |-> wb_dat_o == 32'h00000000)
      else $error("read data not zero between accesses");

endmodule

// ==== include/bfd_regs.svh ====
// register map, field positions, reset values and timing counts
`ifndef BFD_REGS_SVH
`define BFD_REGS_SVH

// widths of the sample path
`define BFD_IW 14
`define BFD_DW 26
`define BFD_CW 2
`define BFD_NCORE 4
`define BFD_NTAP 4
`define BFD_FRAC 8

// register byte offsets
`define BFD_OFF_CTRL 8'h00
`define BFD_OFF_UOFF 8'h04
`define BFD_OFF_TARGET 8'h08
`define BFD_OFF_SKIP 8'h0C
`define BFD_OFF_CAL 8'h10
`define BFD_OFF_COEF 8'h20
`define BFD_OFF_STAT 8'h30
`define BFD_OFF_EST 8'h40

// control fields
`define BFD_CTRL_STAB 0
`define BFD_CTRL_FILT 1

// reset values
`define BFD_RST_STAB 1'b1
`define BFD_RST_FILT 1'b0
`define BFD_RST_SKIP 8'h01
`define BFD_COEF_UNITY 8'h40

// arithmetic scaling
`define BFD_COEF_SHIFT 6
`define BFD_STAB_SHIFT 6

// record span in time and in retained samples
`define BFD_MCLK_MHZ 40
`define BFD_REC_SPAN_US 200
`define BFD_REC_LEN (`BFD_REC_SPAN_US * `BFD_MCLK_MHZ)

`endif

// ==== include/bfd_pkg.sv ====
// types shared by the conditioning chain
`include "bfd_regs.svh"
package bfd_pkg;
   typedef logic signed [`BFD_DW-1:0] bfd_dat_t;
   // raw sample from the interleaved cores
   typedef struct packed {
      logic vld;
      logic first;
      logic [`BFD_CW-1:0] core;
      logic signed [`BFD_IW-1:0] smp;
   } bfd_in_t;
   // sample inside the chain, 8 fraction bits
   typedef struct packed {
      logic vld;
      logic first;
      logic [`BFD_CW-1:0] core;
      bfd_dat_t dat;
   } bfd_smp_t;
   // retained sample toward accumulation
   typedef struct packed {
      logic vld;
      logic first;
      logic last;
      bfd_dat_t dat;
   } bfd_out_t;
   // settings applied on a record boundary
   typedef struct packed {
      logic stab_en;
      logic filt_en;
      logic signed [15:0] uoff;
      logic signed [21:0] target;
      logic [7:0] skip;
      logic [`BFD_NTAP-1:0][7:0] coef;
   } bfd_cfg_t;
endpackage

// ==== test/bfd_adc_model.sv ====
// interleaved adc core model feeding the conditioning chain
`timescale 1ns/10ps
module bfd_adc_model (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic start,
   input wire logic gappy,
   input wire logic [7:0] count,
   output bfd_pkg::bfd_in_t smp_in,
   output logic busy
);
   import bfd_pkg::*;
   logic [7:0] left;
   logic [1:0] core;
   logic first_due;
   int v;
   // fixed per-core offset mismatch of up to 100 codes
   function automatic int mism(input logic [1:0] c);
      return (c == 2'h1) ? 100 : (c == 2'h2) ? -100 : (c == 2'h3) ? 50 : 0;
   endfunction
   assign busy = (left != 8'h00);
   // cores take turns; idle data lines toggle so stale values never match
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         smp_in <= '0;
         left <= 8'h00;
         core <= 2'h0;
         first_due <= 1'b0;
      end else if (start) begin
         left <= count;
         first_due <= 1'b1;
         smp_in.vld <= 1'b0;
      end else if (busy && !(gappy && $urandom_range(1) == 0)) begin
         v = 1000 + mism(core) + int'($urandom_range(63));
         smp_in <= '{vld: 1'b1, first: first_due, core: core, smp: 14'(v)};
         first_due <= 1'b0;
         left <= left - 8'h01;
         core <= core + 2'h1;
      end else begin
         smp_in.vld <= 1'b0;
         smp_in.first <= 1'b0;
         smp_in.smp <= ~smp_in.smp;
      end
   end
endmodule

// ==== test/bfd_chain_tb.sv ====
// self-checking bench for the conditioning chain
`timescale 1ns/10ps
`include "bfd_regs.svh"
module bfd_chain_tb;
   import bfd_pkg::*;
   localparam int RL = 8;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic ack;
   logic start = 1'b0;
   logic gappy = 1'b0;
   logic busy;
   logic [7:0] count = 8'h00;
   bfd_in_t smp_in;
   bfd_out_t smp_out;
   bfd_out_t eq[$];
   bfd_out_t e;
   bfd_cfg_t pend;
   bfd_cfg_t act;
   logic signed [15:0] cal[4] = '{16'sh0, 16'sh0, 16'sh0, 16'sh0};
   bfd_dat_t est[4] = '{26'sh0, 26'sh0, 26'sh0, 26'sh0};
   bfd_dat_t s, d, h1;
   int fail_count = 0;
   int n_compared = 0;
   int cnt, ret, m;
   always #12.5 mclk = ~mclk;
   bfd_chain #(.REC_LEN(RL)) dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .smp_in(smp_in), .smp_out(smp_out));
   bfd_adc_model adc (.mclk(mclk), .rstn(rstn), .start(start), .gappy(gappy), .count(count),
      .smp_in(smp_in), .busy(busy));
   // compare one value, count it
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one classic bus cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= dd;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         close_out();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge mclk);
   endtask
   // write and mirror into the pending settings
   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      wb(1'b1, a, dd);
      if (a == `BFD_OFF_CTRL) {pend.filt_en, pend.stab_en} = dd[1:0];
      if (a == `BFD_OFF_UOFF) pend.uoff = dd[15:0];
      if (a == `BFD_OFF_TARGET) pend.target = dd[21:0];
      if (a == `BFD_OFF_SKIP) pend.skip = dd[7:0];
      if (a[7:4] == 4'h1) cal[a[3:2]] = dd[15:0];
      if (a[7:4] == 4'h2) pend.coef[a[3:2]] = dd[7:0];
   endtask
   task automatic rec(input logic [7:0] n, input logic g);
      start <= 1'b1;
      count <= n;
      gappy <= g;
      @(posedge mclk);
      start <= 1'b0;
   endtask
   task automatic idle();
      int n;
      n = 0;
      @(posedge mclk); // let the model's sample count settle
      while (busy !== 1'b0 && n < 500) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 500) begin
         fail_count++;
         close_out();
      end
      repeat (8) @(posedge mclk);
   endtask
   // expected results, noted as each sample enters
   always @(posedge mclk) begin
      if (rstn && smp_in.vld === 1'b1) begin
         if (smp_in.first) begin
            act = pend;
            cnt = 0;
            ret = 0;
         end
         s = bfd_dat_t'(smp_in.smp) - bfd_dat_t'(cal[smp_in.core]) + bfd_dat_t'(act.uoff);
         s = s <<< 8;
         if (act.stab_en) begin
            d = s - est[smp_in.core] + bfd_dat_t'(act.target);
            est[smp_in.core] = est[smp_in.core] + ((s - est[smp_in.core]) >>> 6);
            s = d;
         end
         d = s;
         if (act.filt_en) begin
            d = (s * bfd_dat_t'($signed(act.coef[0]))
               + h1 * bfd_dat_t'($signed(act.coef[1]))) >>> 6;
         end
         h1 = s;
         m = (act.skip == 8'h00) ? 1 : int'(act.skip);
         if (cnt % m == 0 && ret < RL) begin
            eq.push_back('{vld: !(act.filt_en && cnt == 0), first: ret == 0,
               last: ret == RL - 1, dat: d});
            ret++;
         end
         cnt++;
      end
   end
   // oldest note against each retained sample
   always @(posedge mclk) begin
      if (rstn && smp_out.vld === 1'b1) begin
         if (eq.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            e = eq.pop_front();
            chk(32'(smp_out.first), 32'(e.first));
            chk(32'(smp_out.last), 32'(e.last));
            if (e.vld) chk(smp_out.dat, e.dat);
         end
      end
   end
   initial begin
      pend = '{stab_en: `BFD_RST_STAB, filt_en: `BFD_RST_FILT, uoff: 16'sh0, target: 22'sh0,
         skip: `BFD_RST_SKIP, coef: {4{`BFD_COEF_UNITY}}};
      void'($urandom(55));
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      // reset values and an unmapped place
      wb(1'b0, `BFD_OFF_CTRL, 32'h0);
      chk(q, 32'h1);
      wb(1'b0, `BFD_OFF_SKIP, 32'h0);
      chk(q, 32'h1);
      wb(1'b0, `BFD_OFF_COEF, 32'h0);
      chk(q, 32'(`BFD_COEF_UNITY));
      wb(1'b0, 8'hFC, 32'h0);
      chk(q, 32'h0);
      // stabilizer on, per-core calibration, random target
      for (int i = 0; i < 4; i++) wr(8'(`BFD_OFF_CAL + 4 * i), 32'(int'($urandom_range(200)) - 100));
      wr(`BFD_OFF_TARGET, 32'($urandom_range(20'hFFFFF)));
      wr(`BFD_OFF_UOFF, 32'(int'($urandom_range(400)) - 200));
      rec(8'(RL), 1'b0);
      idle();
      // per-core estimates and record status read back
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, 8'(`BFD_OFF_EST + 4 * i), 32'h0);
         chk(q, 32'(est[i]));
      end
      wb(1'b0, `BFD_OFF_STAT, 32'h0);
      chk(q, 32'(RL));
      // stabilizer off, skip 3, user offset changed mid-record
      wr(`BFD_OFF_CTRL, 32'h0);
      wr(`BFD_OFF_SKIP, 32'h3);
      rec(8'(RL * 3), 1'b0);
      repeat (4) @(posedge mclk);
      wr(`BFD_OFF_UOFF, 32'(int'($urandom_range(400)) - 200));
      idle();
      // filter on with two half taps, skip 2, ragged input spacing
      wr(`BFD_OFF_CTRL, 32'h2);
      for (int i = 0; i < 4; i++) wr(8'(`BFD_OFF_COEF + 4 * i), (i < 2) ? 32'h20 : 32'h0);
      wr(`BFD_OFF_SKIP, 32'h2);
      rec(8'(RL * 2), 1'b1);
      idle();
      chk(32'(eq.size()), 32'h0);
      close_out();
   end
endmodule
